//--- kidp_top.sv
// Key identifier download port: protocol engine and pin stage.
// Assumes key data from same-clock logic and a link clock for the pins.
// Notes on behaviour
// - identifier top four bits hold key mode
// - identifier low 24 bits hold serial number
// - mode coding sampled and latched after power-on
// - later coding changes ignored until power cycle
// - transmitter mode starts unasked on key insertion
// - transmitter bit period is 100 ms
// - two data lines, sync, strobe, two echoes
// - new transmission only after key reinserted
// - no coding link selects transmitter mode
// - controller uses four inputs, two outputs
// - handshake transfers only on controller request
// - handshake uses one line, paced per bit
// - new request sequence repeats the identifier
// - response held high marks identifier end
// - jumper terminal three to input one: handshake
// - reduced variant uses sync as key-valid
// - advanced transfers like handshake plus lock, ack
// - advanced mode selected by DIP setting
// - advanced terminal mapping, lock and ack inputs
// - sync high 100 ms announces transmission
// - echo mismatch aborts, resyncs and restarts
// - handshake sends bit 27 first down to 0
// - response high while bit valid, falls after request
`timescale 1ns/10ps
module kidp_top
  import kidp_pkg::*;
#(
  parameter int unsigned P_MS_CYC = MS_CYC // Cycles per millisecond
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        LINK_CLK_I,
  input  wire logic        KEY_VALID_I,
  input  wire logic [3:0]  KEY_MODE_I,
  input  wire logic [23:0] KEY_SERIAL_I,
  input  wire logic        ADV_MODE_SEL_I,
  input  wire logic        PORT_IN_TERMINAL_0_I,
  input  wire logic        PORT_IN_TERMINAL_1_I,
  input  wire logic        PORT_OUT_TERMINAL_1_I,
  output logic             PORT_OUT_TERMINAL_0_O,
  output logic             PORT_OUT_TERMINAL_1_O,
  output logic             PORT_OUT_TERMINAL_1_OE_N_O,
  output logic             PORT_OUT_TERMINAL_2_O,
  output logic             PORT_OUT_TERMINAL_3_O,
  output logic [1:0]       MODE_O,
  output logic             KEY_LOCK_O,
  output logic             PRESEL_ACK_O
);

  localparam int MSW = $clog2(P_MS_CYC); // Millisecond counter width

  // Link clock domain: reset, pin filters, output stage
  logic [1:0] lrst_r;     // Reset carried into the link domain
  logic [2:0] pin_a_r;    // Pin sampler, first stage
  logic [2:0] pin_b_r;    // Second stage
  logic [2:0] pin_c_r;    // Third stage
  logic [2:0] pin_f_r;    // Filtered pin levels
  logic [4:0] out_m_r;    // Output crossing, first stage
  logic [4:0] out_s_r;    // Output crossing, second stage

  // System clock domain
  logic [2:0]  in_m_r;    // Pin levels crossing, first stage
  logic [2:0]  in_s_r;    // Pin levels in system domain
  kidp_state_e st_r;      // Protocol state
  kidp_state_e st_nxt;    // Next protocol state
  kidp_mode_e  mode_r;    // Latched communication mode
  logic [MSW-1:0] cyc_r;  // Cycles within current millisecond
  logic [7:0]  ms_r;      // Milliseconds spent in current state
  logic [27:0] keyid_r;   // Identifier being sent
  logic [4:0]  idx_r;     // Bit index being sent
  logic [4:0]  out_nxt;   // Pin vector to present next
  logic [4:0]  sys_out_r; // Pin vector, registered
  logic        lock_r;    // Lock request, advanced mode
  logic        ack_r;     // Preselection acceptance, advanced mode
  logic        tick;      // Last cycle of a millisecond
  logic        req;       // Controller bit request
  logic        kv;        // Key present and valid
  logic        up_bit;    // Upper-half bit on transmit
  logic        lo_bit;    // Lower-half bit on transmit
  logic        echo_ok;   // Echo equals the sent pair
  logic        t_probe;   // Probe time over
  logic        t_sync;    // Sync time over
  logic        t_stb;     // Strobe half period over
  logic        t_acc;     // Access or release time over
  logic        t_end;     // End marker time over

  // Reset into link domain; first stage feeds only the second
  always_ff @(posedge LINK_CLK_I) begin
    lrst_r <= {lrst_r[0], SRST_I};
  end

  // Three-stage pin samplers; a level counts once stages 2 and 3 agree
  always_ff @(posedge LINK_CLK_I) begin
    pin_a_r <= {PORT_OUT_TERMINAL_1_I, PORT_IN_TERMINAL_1_I,
                PORT_IN_TERMINAL_0_I};
    pin_b_r <= pin_a_r;
    pin_c_r <= pin_b_r;
  end

  // Per-pin agreement filter
  for (genvar g = 0; g < 3; g++) begin : g_filt
    always_ff @(posedge LINK_CLK_I) begin
      if (lrst_r[1]) begin
        pin_f_r[g] <= 1'b0;
      end else if (pin_b_r[g] == pin_c_r[g]) begin
        pin_f_r[g] <= pin_b_r[g];
      end
    end
  end

  // Output levels into link domain; pins change at ms pace, so
  // a one-cycle skew between bits is harmless
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_r[1]) begin
      out_m_r <= OUT_RST;
      out_s_r <= OUT_RST;
    end else begin
      out_m_r <= sys_out_r;
      out_s_r <= out_m_r;
    end
  end

  assign PORT_OUT_TERMINAL_0_O      = out_s_r[0];
  assign PORT_OUT_TERMINAL_1_O      = out_s_r[1];
  assign PORT_OUT_TERMINAL_2_O      = out_s_r[2];
  assign PORT_OUT_TERMINAL_3_O      = out_s_r[3];
  assign PORT_OUT_TERMINAL_1_OE_N_O = out_s_r[4];

  // Filtered pin levels into system domain
  always_ff @(posedge SYS_CLK_I) begin
    in_m_r <= pin_f_r;
    in_s_r <= in_m_r;
  end

  // Request pin depends on mode: input 0, or terminal 1 in advanced
  assign req = (mode_r == MODE_ADV) ? in_s_r[2] : in_s_r[0];
  assign kv  = KEY_VALID_I;

  // Sent pair and its echo check
  assign up_bit  = keyid_r[5'(idx_r + HALF_OFS)];
  assign lo_bit  = keyid_r[idx_r];
  assign echo_ok = (in_s_r[0] == up_bit) && (in_s_r[1] == lo_bit);

  // Millisecond time base; restarted on every state change
  assign tick    = (cyc_r == MSW'(P_MS_CYC - 1));
  assign t_probe = tick && (ms_r == T_PROBE_MS - 8'h01);
  assign t_sync  = tick && (ms_r == T_SYNC_MS - 8'h01);
  assign t_stb   = tick && (ms_r == T_STB_MS - 8'h01);
  assign t_acc   = tick && (ms_r == T_ACC_MS - 8'h01);
  assign t_end   = tick && (ms_r == T_END_MS - 8'h01);

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || (st_nxt != st_r)) begin
      cyc_r <= '0;
      ms_r  <= 8'h00;
    end else if (tick) begin
      cyc_r <= '0;
      ms_r  <= ms_r + 8'h01; // Wraps while waiting; harmless
    end else begin
      cyc_r <= cyc_r + 1'b1;
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_PROBE: begin
        if (t_probe) st_nxt = S_IDLE;
      end
      S_IDLE: begin
        // Unasked start in transmitter mode
        if (kv) begin
          st_nxt = (mode_r == MODE_TX) ? S_SYNC : S_HWAIT;
        end
      end
      S_SYNC: begin
        if (t_sync) st_nxt = S_BLO;
      end
      S_BLO: begin
        if (t_stb) st_nxt = S_BHI;
      end
      S_BHI: begin
        if (t_stb) begin
          if (!echo_ok) begin
            st_nxt = S_SYNC;
          end else if (idx_r == 5'h00) begin
            st_nxt = S_DONE;
          end else begin
            st_nxt = S_BLO;
          end
        end
      end
      S_DONE: begin
        st_nxt = S_DONE; // Leaves only on key removal
      end
      S_HWAIT: begin
        if (req) st_nxt = S_HACC;
      end
      S_HACC: begin
        if (t_acc) st_nxt = S_HRESP;
      end
      S_HRESP: begin
        // Request fell: bit taken by the controller
        if (!req) begin
          st_nxt = (idx_r == 5'h00) ? S_HEND : S_HREL;
        end
      end
      S_HREL: begin
        if (t_acc) st_nxt = S_HWAIT;
      end
      S_HEND: begin
        if (t_end) st_nxt = S_HWAIT;
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
    // Key loss ends any transfer at once
    if (st_r != S_PROBE && !kv) st_nxt = S_IDLE;
  end

  // State register; probe runs only after power-on reset
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) st_r <= S_PROBE;
    else        st_r <= st_nxt;
  end

  // Mode latched once at probe end, never again
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      mode_r <= MODE_TX;
    end else if (st_r == S_PROBE && t_probe) begin
      if (ADV_MODE_SEL_I)  mode_r <= MODE_ADV;
      else if (in_s_r[1])  mode_r <= MODE_HS;
      else                 mode_r <= MODE_TX;
    end
  end

  // Identifier captured while idle, frozen during transfer
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      keyid_r <= 28'h0000000;
    end else if (st_r == S_IDLE) begin
      keyid_r[MODE_MSB:MODE_LSB] <= KEY_MODE_I;
      keyid_r[SER_MSB:SER_LSB]   <= KEY_SERIAL_I;
    end
  end

  // Bit index: counts down, MSB first
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      idx_r <= LAST_HS_IDX;
    end else begin
      case (st_r)
        S_IDLE: begin
          idx_r <= (mode_r == MODE_TX) ? LAST_TX_IDX : LAST_HS_IDX;
        end
        S_SYNC: begin
          idx_r <= LAST_TX_IDX; // Restart from the top
        end
        S_BHI: begin
          if (t_stb && echo_ok && idx_r != 5'h00) idx_r <= idx_r - 5'h01;
        end
        S_HREL: begin
          if (t_acc) idx_r <= idx_r - 5'h01;
        end
        S_HEND: begin
          if (t_end) idx_r <= LAST_HS_IDX;
        end
        default: begin
          idx_r <= idx_r;
        end
      endcase
    end
  end

  // Pin vector per mode; terminals low while idle or done, t3 driven during the probe
  always_comb begin
    logic syn;
    logic hs_on;
    logic resp;
    logic dat;
    syn   = 1'b0;
    hs_on = st_r inside {S_HWAIT, S_HACC, S_HRESP, S_HREL, S_HEND};
    resp  = st_r inside {S_HRESP, S_HEND};
    dat   = (st_r inside {S_HACC, S_HRESP, S_HREL}) ? lo_bit : 1'b0;
    out_nxt = OUT_RST;
    case (mode_r)
      MODE_TX: begin
        // Sync, strobe and two halves
        syn = (st_r == S_SYNC);
        out_nxt = {1'b0,
                   (st_r inside {S_BLO, S_BHI}) ? lo_bit : 1'b0,
                   (st_r inside {S_BLO, S_BHI}) ? up_bit : 1'b0,
                   st_r == S_BHI, syn};
      end
      MODE_HS: begin
        // Sync alone serves the reduced variant
        out_nxt = {1'b0, 1'b0, dat, resp, hs_on};
      end
      MODE_ADV: begin
        // Terminal 1 released for the request
        out_nxt = {1'b1, hs_on, dat, 1'b0, resp};
      end
      default: begin
        out_nxt = OUT_RST;
      end
    endcase
    if (st_r == S_PROBE) out_nxt = OUT_PROBE; // Drive coding out
  end

  // Registered pin vector and status
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      sys_out_r <= OUT_RST;
      lock_r    <= 1'b0;
      ack_r     <= 1'b0;
    end else begin
      sys_out_r <= out_nxt;
      lock_r    <= (mode_r == MODE_ADV) && in_s_r[0];
      ack_r     <= (mode_r == MODE_ADV) && in_s_r[1];
    end
  end

  assign MODE_O       = mode_r;
  assign KEY_LOCK_O   = lock_r;
  assign PRESEL_ACK_O = ack_r;

  // Checks, all in the system clock domain
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence probe_end_s;
    st_r == S_PROBE && t_probe;
  endsequence
  sequence hs_end_s;
    st_r == S_HEND && t_end && kv;
  endsequence

  mode_hold_a: assert property (
    st_r != S_PROBE |=> $stable(mode_r))
    else $error("Mode changed after power-on");
  mode_tx_a: assert property (
    probe_end_s ##0 (!ADV_MODE_SEL_I && !in_s_r[1])
    |=> mode_r == MODE_TX) else $error("Transmitter mode not chosen");
  mode_hs_a: assert property (
    probe_end_s ##0 (!ADV_MODE_SEL_I && in_s_r[1])
    |=> mode_r == MODE_HS) else $error("Handshake mode not chosen");
  mode_adv_a: assert property (
    probe_end_s ##0 ADV_MODE_SEL_I |=> mode_r == MODE_ADV)
    else $error("Advanced mode not chosen");
  tx_start_a: assert property (
    (mode_r == MODE_TX && st_r == S_IDLE && kv)
    |=> st_r == S_SYNC ##1 sys_out_r[0])
    else $error("Transmission did not start with sync");
  echo_retry_a: assert property (
    (st_r == S_BHI && t_stb && !echo_ok && kv) |=> st_r == S_SYNC)
    else $error("Echo mismatch did not restart");
  bit_step_a: assert property (
    (st_r == S_BHI && t_stb && echo_ok && idx_r != 5'h00 && kv)
    |=> st_r == S_BLO && idx_r == $past(idx_r) - 5'h01)
    else $error("Bit period did not advance");
  no_unasked_a: assert property (
    (st_r == S_HWAIT && !req) |=> st_r inside {S_HWAIT, S_IDLE})
    else $error("Bit sent without request");
  msb_first_a: assert property (
    hs_end_s |=> st_r == S_HWAIT && idx_r == LAST_HS_IDX)
    else $error("Repeat does not start at bit 27");
  resp_fall_a: assert property (
    (st_r == S_HRESP && !req && idx_r != 5'h00 && kv)
    |=> st_r == S_HREL) else $error("Response kept after request");
  end_mark_a: assert property (
    (st_r == S_HRESP && !req && idx_r == 5'h00 && kv)
    |=> (st_r == S_HEND) [*8])
    else $error("End marker cut short");
  key_fields_a: assert property (
    st_r == S_IDLE |=> keyid_r == {$past(KEY_MODE_I),
                                    $past(KEY_SERIAL_I)})
    else $error("Identifier fields misplaced");
  idle_low_a: assert property (
    st_r == S_IDLE |=> sys_out_r[3:0] == 4'h0)
    else $error("Pins not low while idle");

endmodule : kidp_top

//--- kidp_pkg.sv
// Constants and types for the key identifier download port.
// Assumes a 125 MHz system clock; link times are whole milliseconds.
package kidp_pkg;
  // Clock rate and the cycle count of one millisecond
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // Identifier layout: mode in the top nibble, serial below
  localparam int ID_W     = 28;
  localparam int MODE_MSB = 27;
  localparam int MODE_LSB = 24;
  localparam int SER_MSB  = 23;
  localparam int SER_LSB  = 0;
  // Transmitter mode splits the identifier over two lines
  localparam logic [4:0] HALF_OFS    = 5'h0E;
  localparam logic [4:0] LAST_TX_IDX = 5'h0D;
  localparam logic [4:0] LAST_HS_IDX = 5'h1B;
  // Times in milliseconds
  localparam logic [7:0] T_SYNC_MS  = 8'h64; // Start announcement
  localparam logic [7:0] T_BIT_MS   = 8'h64; // Bit period
  localparam logic [7:0] T_STB_MS   = T_BIT_MS >> 1; // Half period
  localparam logic [7:0] T_ACC_MS   = 8'h0A; // Access and release
  localparam logic [7:0] T_END_MS   = 8'hC8; // End-of-identifier
  // Coding probe; must outlast the loop through both pin crossings,
  // which matters when a millisecond is only a few cycles long
  localparam logic [7:0] T_PROBE_MS = 8'h04;
  // Pin vector {t1 enable_n, t3, t2, t1, t0}; reset releases t1
  localparam logic [4:0] OUT_RST    = 5'h10;
  localparam logic [4:0] OUT_PROBE  = 5'h18;
  // Communication modes
  typedef enum logic [1:0] {
    MODE_TX  = 2'h0,
    MODE_HS  = 2'h1,
    MODE_ADV = 2'h3
  } kidp_mode_e;
  // Controller states, Gray coded along the usual path
  typedef enum logic [3:0] {
    S_PROBE = 4'h0,
    S_IDLE  = 4'h1,
    S_SYNC  = 4'h3,
    S_BLO   = 4'h2,
    S_BHI   = 4'h6,
    S_DONE  = 4'h7,
    S_HWAIT = 4'h5,
    S_HACC  = 4'h4,
    S_HRESP = 4'hC,
    S_HREL  = 4'hD,
    S_HEND  = 4'hF
  } kidp_state_e;
endpackage : kidp_pkg

//--- kidp_plc_model.sv
// Behavioural controller model for the key identifier download port.
// Assumes the link clock as its scan cycle and bench-made pin levels.
`timescale 1ns/10ps
module kidp_plc_model (
  input  wire logic       clk_i,   // Scan cycle
  input  wire logic [1:0] mode_i,  // Wiring: 0 tx, 1 hs, 3 adv
  input  wire logic       bad_i,   // Corrupt the echo while high
  input  wire logic       go_i,    // Rise starts a request sequence
  input  wire logic [4:0] nbits_i, // Bits per request sequence
  input  wire logic [3:0] hold_i,  // Extra scans before release
  input  wire logic       lock_i,  // Lock output level
  input  wire logic       ack_i,   // Preselection acceptance level
  input  wire logic [3:0] pin_i,   // Terminal levels 3..0
  output logic            in0_o,   // Device input terminal 0
  output logic            in1_o,   // Device input terminal 1
  output logic            t1_o,    // Request driven on terminal 1
  output logic            rx_o,    // Pulse for each bit read
  output logic [1:0]      bits_o   // Bits read at that pulse
);
  logic [1:0] echo = 2'h0;   // Echo lines, 0 outside strobe high
  logic       req = 1'b0;    // Request line
  logic       stb_q = 1'b0;  // Strobe at the last scan
  logic       rx_tx = 1'b0;  // Pair read in transmitter mode
  logic       rx_hs = 1'b0;  // Bit read in handshake modes
  logic [1:0] b_tx = 2'h0;   // Last pair read
  logic       b_hs = 1'b0;   // Last serial bit read
  logic       resp;          // Response as the controller sees it
  assign resp = (mode_i == 2'h3) ? pin_i[0] : pin_i[1];
  // Wiring per mode; the coding jumper ties terminal 3 to input 1
  assign in0_o = (mode_i == 2'h0) ? echo[1] :
                 (mode_i == 2'h1) ? req : lock_i;
  assign in1_o = (mode_i == 2'h0) ? echo[0] :
                 (mode_i == 2'h1) ? pin_i[3] : ack_i;
  assign t1_o = req;
  assign rx_o = rx_tx | rx_hs;
  assign bits_o = (mode_i == 2'h0) ? b_tx : {1'b0, b_hs};
  // Echo taken at strobe rise, lines back at 0 from its fall
  always @(posedge clk_i) begin
    stb_q <= pin_i[1];
    rx_tx <= 1'b0;
    if (mode_i == 2'h0 && pin_i[1] && !stb_q) begin
      b_tx <= {pin_i[2], pin_i[3]};
      echo <= bad_i ? ~{pin_i[2], pin_i[3]} : {pin_i[2], pin_i[3]};
      rx_tx <= 1'b1;
    end else if (mode_i == 2'h0 && !pin_i[1] && stb_q) begin
      echo <= 2'h0;
    end
  end
  // One bit per request; never faster than two scans per bit
  always @(posedge go_i) begin
    for (int i = 0; i < nbits_i; i++) begin
      @(posedge clk_i);
      req <= 1'b1;
      wait (resp === 1'b1);
      @(posedge clk_i);
      b_hs <= pin_i[2];
      rx_hs <= 1'b1;
      @(posedge clk_i);
      rx_hs <= 1'b0;
      repeat (hold_i) @(posedge clk_i);
      req <= 1'b0;
      wait (resp === 1'b0);
      @(posedge clk_i);
    end
  end
endmodule : kidp_plc_model

//--- tb_key_id_download_port.sv
// Self-checking bench for the key identifier download port.
// Assumes kidp_top and kidp_plc_model; one millisecond is 16 cycles.
`timescale 1ns/10ps
module tb_key_id_download_port;
  import kidp_pkg::*;
  localparam int MS = 16;         // Shortened millisecond
  logic        clk = 1'b0;        // System clock
  logic        lclk = 1'b0;       // Link clock
  logic        srst = 1'b1;       // Reset, stands for power-on
  logic        key = 1'b0;        // Key present and valid
  logic        adv = 1'b0;        // DIP advanced select
  logic        bad = 1'b0;        // Ask for a wrong echo
  logic        go = 1'b0;         // Start request sequence
  logic        lock = 1'b0;       // Controller lock output
  logic        ack = 1'b0;        // Controller acceptance output
  logic [3:0]  kmode = 4'h0;      // Key mode field
  logic [3:0]  hold = 4'h0;       // Controller slowness
  logic [23:0] ser = 24'h000000;  // Key serial field
  logic [4:0]  nb = 5'h00;        // Bits per sequence
  logic [1:0]  pm = 2'h0;         // Controller wiring mode
  logic        in0, in1, t1d, rx; // Controller side
  logic [1:0]  rbits, mode;       // Bits read, latched mode
  logic        t0, t1, oe_n, t2, t3, klock, pack;
  logic        t1w;               // Resolved terminal 1 level
  logic [3:0]  pins;              // Terminal levels 3..0
  logic [1:0]  expq[$];           // Expected reads, oldest first
  logic [27:0] id;                // Expected identifier
  int          err_total = 0;
  int          num_checks = 0;
  int          n, p;              // Cycle counts of the last wait
  // Terminal 1 is two-way: the controller drives it when released
  assign t1w = (oe_n === 1'b0) ? t1 : t1d;
  assign pins = {t3, t2, t1w, t0};
  always #4 clk = ~clk;
  // Link clock with an unrelated phase
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  kidp_top #(.P_MS_CYC(MS)) dut (
    .SYS_CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(lclk),
    .KEY_VALID_I(key), .KEY_MODE_I(kmode), .KEY_SERIAL_I(ser),
    .ADV_MODE_SEL_I(adv), .PORT_IN_TERMINAL_0_I(in0),
    .PORT_IN_TERMINAL_1_I(in1), .PORT_OUT_TERMINAL_1_I(t1w),
    .PORT_OUT_TERMINAL_0_O(t0), .PORT_OUT_TERMINAL_1_O(t1),
    .PORT_OUT_TERMINAL_1_OE_N_O(oe_n), .PORT_OUT_TERMINAL_2_O(t2),
    .PORT_OUT_TERMINAL_3_O(t3), .MODE_O(mode), .KEY_LOCK_O(klock),
    .PRESEL_ACK_O(pack));
  kidp_plc_model plc (
    .clk_i(lclk), .mode_i(pm), .bad_i(bad), .go_i(go), .nbits_i(nb),
    .hold_i(hold), .lock_i(lock), .ack_i(ack), .pin_i(pins),
    .in0_o(in0), .in1_o(in1), .t1_o(t1d), .rx_o(rx), .bits_o(rbits));
  // Compare and count one result
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait for a terminal level; n holds the cycles waited
  task automatic wait_pin(input int k, input logic v, input int lim);
    n = 0;
    while (pins[k] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(n < lim, 1'b1);
  endtask : wait_pin
  // Bounded wait until every expected read has been seen
  task automatic drain(input int lim);
    n = 0;
    while (expq.size() != 0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(n < lim, 1'b1);
  endtask : drain
  // Reset doubles as a power cycle with new wiring
  task automatic power_on(input logic [1:0] m);
    @(negedge clk);
    srst = 1'b1;
    key = 1'b0;
    pm = m;
    adv = (m == 2'h3);
    repeat (12) @(negedge clk);
    srst = 1'b0;
    // Let the coding probe end and its pin level drain out
    repeat (120) @(negedge clk);
    kmode = 4'($urandom);
    ser = 24'($urandom);
    id = {kmode, ser};
  endtask : power_on
  // Oldest note is matched against each read of the controller
  always @(posedge rx) begin
    // Pulse and bits change in one step; let both settle first
    #1;
    if (expq.size() == 0) check(1'b1, 1'b0);
    else check(rbits, expq.pop_front());
  end
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Watchdog well beyond the expected run length
  initial begin
    #800_000;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h8487d4cd));
    // Transmitter mode: no coding link present
    power_on(2'h0);
    check(mode, MODE_TX);
    check(pins, 4'h0);
    bad = 1'b1;
    expq.push_back({id[27], id[13]});
    for (int i = 13; i >= 0; i--) expq.push_back({id[14 + i], id[i]});
    key = 1'b1;
    wait_pin(0, 1'b1, 100);
    wait_pin(0, 1'b0, 2000);
    check(n > 1592 && n < 1608, 1'b1);
    wait_pin(0, 1'b1, 2400);
    bad = 1'b0;
    adv = 1'b1;
    // Sync and the strobe-low half take 2400 of the 2600-cycle limit
    wait_pin(1, 1'b1, 2600);
    wait_pin(1, 1'b0, 1000);
    p = n;
    wait_pin(1, 1'b1, 1000);
    check(p + n > 1592 && p + n < 1608, 1'b1);
    drain(30000);
    repeat (1000) @(negedge clk);
    check(pins, 4'h0);
    check(mode, MODE_TX);
    p = 0;
    repeat (2400) begin
      @(negedge clk);
      p += pins[0];
    end
    check(p, 0);
    key = 1'b0;
    repeat (40) @(negedge clk);
    key = 1'b1;
    wait_pin(0, 1'b1, 100);
    key = 1'b0;
    repeat (40) @(negedge clk);
    check(pins, 4'h0);
    // Handshake mode through the coding jumper
    power_on(2'h1);
    check(mode, MODE_HS);
    key = 1'b1;
    repeat (400) @(negedge clk);
    check(pins[1:0], 2'h1);
    for (int i = 27; i >= 0; i--) expq.push_back({1'b0, id[i]});
    hold = 4'($urandom);
    nb = 5'h1C;
    go = 1'b1;
    drain(20000);
    check(n >= 28 * 20 * MS, 1'b1);
    go = 1'b0;
    wait_pin(1, 1'b0, 4000);
    check(n > 3150 && n < 3330, 1'b1);
    repeat (10) @(negedge clk);
    expq.push_back({1'b0, id[27]});
    expq.push_back({1'b0, id[26]});
    nb = 5'h02;
    go = 1'b1;
    drain(2000);
    go = 1'b0;
    key = 1'b0;
    repeat (40) @(negedge clk);
    check(pins, 4'h0);
    // Advanced mode through the DIP select
    power_on(2'h3);
    check(mode, MODE_ADV);
    check(oe_n, 1'b1);
    repeat (4) begin
      lock = 1'($urandom);
      ack = 1'($urandom);
      repeat (60) @(negedge clk);
      check({klock, pack}, {lock, ack});
    end
    key = 1'b1;
    repeat (60) @(negedge clk);
    check(pins[3], 1'b1);
    for (int i = 27; i >= 0; i--) expq.push_back({1'b0, id[i]});
    nb = 5'h1C;
    go = 1'b1;
    drain(20000);
    go = 1'b0;
    give_verdict();
  end
endmodule : tb_key_id_download_port
